// file: hw/seeb_slave.sv
// Summary of operation
// - first byte after start is control, msb one
// - match select bits, middle pin inverted
// - block bits form upper address bits
// - control lsb: one read, zero write
// - ack write control, then expect address
// - load address pointer, ack, ack data
// - stop starts timed write; no acks meanwhile
// - up to sixteen bytes buffered, committed after stop
// - data bytes bump low four pointer bits
// - extra bytes wrap and overwrite buffer
// - polling: nack while busy, ack after
// - write protect pin blocks all programming
// - counter holds last address plus one
// - read: ack, send byte, nack+stop ends
// - address-only write keeps pointer, no cycle
// - master ack advances pointer, next byte
// - whole range 000 to 7FF usable
// - sda moves only while scl low
// - acknowledger holds sda low through clock high
// - release sda after master nack
`include "seeb_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module seeb_slave #(
    parameter int TWR_CYC = `SEEB_TWR_CYC,
    parameter int AW = `SEEB_AW,
    parameter int PAGE = `SEEB_PAGE
) (
    input wire logic mclk,
    input wire logic rstn,
    seeb_if.slave bus,
    input wire logic chip_select_pin_low,
    input wire logic chip_select_pin_mid_inverted,
    input wire logic chip_select_pin_high,
    input wire logic write_protect,
    output logic write_busy
);
    import seeb_pkg::*;

    // ****************************************
    // input synchronisers
    // ****************************************
    logic [3:0] pin_s1_q;
    logic [3:0] pin_s2_q;
    logic [2:0] scl_q;
    logic [2:0] sda_q;
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            pin_s1_q <= 4'h0;
            pin_s2_q <= 4'h0;
            scl_q <= 3'h7;
            sda_q <= 3'h7;
        end
        else
        begin
            pin_s1_q <= {write_protect, chip_select_pin_high,
                         chip_select_pin_mid_inverted, chip_select_pin_low};
            pin_s2_q <= pin_s1_q;
            scl_q <= {scl_q[1:0], bus.scl};
            sda_q <= {sda_q[1:0], bus.sda};
        end
    end

    logic wp;
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;
    assign wp = pin_s2_q[3];
    assign scl_rise = scl_q[1] && !scl_q[2];
    assign scl_fall = !scl_q[1] && scl_q[2];
    assign start_ev = scl_q[1] && scl_q[2] && sda_q[2] && !sda_q[1];
    assign stop_ev = scl_q[1] && scl_q[2] && !sda_q[2] && sda_q[1];

    // ****************************************
    // protocol state
    // ****************************************
    seeb_sst_t st_q;
    logic [3:0] bc_q;
    logic [7:0] sr_q;
    logic [7:0] tx_q;
    logic [AW-1:0] ptr_q;
    logic [2:0] blk_q;
    logic oe_q;
    logic mack_q;
    logic busy_q;
    logic ctrl_hit;
    logic [7:0] rd_byte;
    logic [AW-1:0] rd_addr;
    logic [7:0] mem_q [2**AW];

    assign ctrl_hit = sr_q[7] && (sr_q[6] == pin_s2_q[2])
                      && (sr_q[5] == !pin_s2_q[1]) && (sr_q[4] == pin_s2_q[0])
                      && !busy_q;
    assign rd_addr = (st_q == SST_CTRL) ? {sr_q[3:1], ptr_q[7:0]} : ptr_q;
    assign rd_byte = mem_q[rd_addr];

    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            st_q <= SST_IDLE;
            bc_q <= 4'h0;
            sr_q <= 8'h00;
            tx_q <= 8'h00;
            ptr_q <= '0;
            blk_q <= 3'h0;
            oe_q <= 1'b0;
            mack_q <= 1'b0;
        end
        else if (start_ev)
        begin
            st_q <= SST_CTRL;
            bc_q <= 4'h0;
            oe_q <= 1'b0;
        end
        else if (stop_ev)
        begin
            st_q <= SST_IDLE;
            bc_q <= 4'h0;
            oe_q <= 1'b0;
        end
        else if (st_q != SST_IDLE && st_q != SST_IGNORE)
        begin
            if (scl_rise)
            begin
                if (bc_q < 4'h8 && st_q != SST_READ)
                begin
                    sr_q <= {sr_q[6:0], sda_q[1]};
                end
                if (bc_q == 4'h8)
                begin
                    mack_q <= !sda_q[1];
                end
                if (bc_q < 4'h9)
                begin
                    bc_q <= bc_q + 4'h1;
                end
            end
            else if (scl_fall && bc_q == 4'h8)
            begin
                // ack driven from this fall to next
                case (st_q)
                    SST_CTRL:
                    begin
                        oe_q <= ctrl_hit;
                        blk_q <= sr_q[3:1];
                        if (ctrl_hit && sr_q[0])
                        begin
                            tx_q <= rd_byte;
                            ptr_q <= rd_addr + 1'b1;
                        end
                    end
                    SST_ADDR:
                    begin
                        // pointer load, no write cycle yet
                        ptr_q <= {blk_q, sr_q};
                        oe_q <= 1'b1;
                    end
                    SST_WDATA:
                    begin
                        ptr_q[3:0] <= ptr_q[3:0] + 4'h1;
                        oe_q <= 1'b1;
                    end
                    default:
                    begin
                        oe_q <= 1'b0;
                    end
                endcase
            end
            else if (scl_fall && bc_q == 4'h9)
            begin
                bc_q <= 4'h0;
                oe_q <= 1'b0;
                case (st_q)
                    SST_CTRL:
                    begin
                        if (!oe_q)
                        begin
                            st_q <= SST_IGNORE;
                        end
                        else if (sr_q[0])
                        begin
                            st_q <= SST_READ;
                            oe_q <= !tx_q[7];
                        end
                        else
                        begin
                            st_q <= SST_ADDR;
                        end
                    end
                    SST_ADDR:
                    begin
                        st_q <= SST_WDATA;
                    end
                    SST_READ:
                    begin
                        if (mack_q)
                        begin
                            tx_q <= rd_byte;
                            ptr_q <= ptr_q + 1'b1;
                            oe_q <= !rd_byte[7];
                        end
                        else
                        begin
                            st_q <= SST_IGNORE;
                        end
                    end
                    default:
                    begin
                        st_q <= st_q;
                    end
                endcase
            end
            else if (scl_fall && st_q == SST_READ && bc_q != 4'h0)
            begin
                oe_q <= !tx_q[3'd7 - bc_q[2:0]];
            end
        end
    end

    // ****************************************
    // page buffer
    // ****************************************
    logic [7:0] pbuf_q [PAGE];
    logic [PAGE-1:0] vld_q;
    logic data_take;
    assign data_take = scl_fall && bc_q == 4'h8 && st_q == SST_WDATA;

    always_ff @(posedge mclk)
    begin
        if (data_take)
        begin
            pbuf_q[ptr_q[3:0]] <= sr_q;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            vld_q <= '0;
        end
        else if (scl_fall && bc_q == 4'h8 && st_q == SST_CTRL && ctrl_hit && !sr_q[0])
        begin
            vld_q <= '0;
        end
        // hold until next write control, later bytes overwrite
        else if (data_take)
        begin
            vld_q[ptr_q[3:0]] <= 1'b1;
        end
    end

    // ****************************************
    // self-timed write cycle
    // ****************************************
    logic wr_go;
    logic commit_q;
    logic [3:0] ci_q;
    logic [31:0] twr_q;
    logic [AW-5:0] base_q;
    // stop after data, protect blocks it
    assign wr_go = stop_ev && st_q == SST_WDATA && (|vld_q) && !wp;

    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            busy_q <= 1'b0;
            commit_q <= 1'b0;
            ci_q <= 4'h0;
            twr_q <= 32'h0;
            base_q <= '0;
        end
        else if (wr_go)
        begin
            busy_q <= 1'b1;
            commit_q <= 1'b1;
            ci_q <= 4'h0;
            twr_q <= 32'(TWR_CYC - 1);
            base_q <= ptr_q[AW-1:4];
        end
        else if (busy_q)
        begin
            if (twr_q == 32'h0)
            begin
                busy_q <= 1'b0;
            end
            else
            begin
                twr_q <= twr_q - 32'h1;
            end
            if (commit_q)
            begin
                ci_q <= ci_q + 4'h1;
                commit_q <= (ci_q != 4'(PAGE - 1));
            end
        end
    end

    // committed one entry per cycle, full range
    always_ff @(posedge mclk)
    begin
        if (commit_q && vld_q[ci_q])
        begin
            mem_q[{base_q, ci_q}] <= pbuf_q[ci_q];
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    logic sda_o_q;
    logic busy_out_q;
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            sda_o_q <= 1'b0;
            busy_out_q <= 1'b0;
        end
        else
        begin
            sda_o_q <= 1'b0;
            busy_out_q <= busy_q;
        end
    end
    assign bus.sda_s_o = sda_o_q;
    assign bus.sda_s_oe = oe_q;
    assign write_busy = busy_out_q;
endmodule
`default_nettype wire

// file: shared/seeb_defines.svh
`ifndef SEEB_DEFINES_SVH
`define SEEB_DEFINES_SVH
// ****************************************
// clock and timing
// ****************************************
`define SEEB_CLK_MHZ 200
`define SEEB_TWR_MS 5
`define SEEB_TWR_CYC (`SEEB_TWR_MS * `SEEB_CLK_MHZ * 1000)
`define SEEB_SCL_KHZ 400
`define SEEB_QTR_CYC ((`SEEB_CLK_MHZ * 1000) / (4 * `SEEB_SCL_KHZ))
// ****************************************
// memory geometry
// ****************************************
`define SEEB_AW 11
`define SEEB_PAGE 16
// ****************************************
// controller register map
// ****************************************
`define SEEB_OFS_CTRL 8'h00
`define SEEB_OFS_ADDR 8'h04
`define SEEB_OFS_STAT 8'h08
`define SEEB_OFS_DATA 8'h40
`define SEEB_CTRL_OP_LSB 0
`define SEEB_CTRL_CS_LSB 4
`define SEEB_CTRL_CNT_LSB 8
`define SEEB_STAT_BUSY 0
`define SEEB_STAT_NACK 1
`endif

// file: shared/seeb_pkg.sv
package seeb_pkg;
    typedef enum logic [2:0] {
        SST_IDLE = 3'b000,
        SST_CTRL = 3'b001,
        SST_ADDR = 3'b010,
        SST_WDATA = 3'b011,
        SST_READ = 3'b100,
        SST_IGNORE = 3'b101
    } seeb_sst_t;
    typedef enum logic [1:0] {
        MST_IDLE = 2'b00,
        MST_START = 2'b01,
        MST_BIT = 2'b10,
        MST_STOP = 2'b11
    } seeb_mst_t;
    typedef enum logic [1:0] {
        OP_WRITE = 2'b00,
        OP_CUR_READ = 2'b01,
        OP_RAND_READ = 2'b10,
        OP_POLL = 2'b11
    } seeb_op_t;
endpackage

// file: shared/seeb_if.sv
`timescale 1ns/1ps
`default_nettype none
interface seeb_if;
    logic scl;
    logic sda_m_o;
    logic sda_m_oe;
    logic sda_s_o;
    logic sda_s_oe;
    logic sda;
    // open drain: any enabled low driver wins, else pull-up
    assign sda = !(sda_m_oe && !sda_m_o) && !(sda_s_oe && !sda_s_o);
    modport master (output scl, output sda_m_o, output sda_m_oe, input sda);
    modport slave (input scl, output sda_s_o, output sda_s_oe, input sda);
endinterface
`default_nettype wire

// file: hw/seeb_master.sv
`include "seeb_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module seeb_master #(
    parameter int QTR = `SEEB_QTR_CYC,
    parameter int PAGE = `SEEB_PAGE
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    seeb_if.master bus
);
    import seeb_pkg::*;

    // ****************************************
    // avalon slave
    // ****************************************
    logic wait_q;
    logic [31:0] rdata_q;
    logic [1:0] op_q;
    logic [2:0] cs_q;
    logic [3:0] n_q;
    logic [10:0] addr_q;
    logic busy_q;
    logic nack_q;
    logic [7:0] wbuf_q [PAGE];
    logic [7:0] rbuf_q [PAGE];
    logic we;
    logic is_data;
    logic [31:0] rmux;
    assign we = avs_write && !wait_q;
    assign is_data = avs_address[7:6] == `SEEB_OFS_DATA >> 6;

    always_comb
    begin
        rmux = 32'h0;
        if (is_data)
            rmux = {24'h0, rbuf_q[avs_address[5:2]]};
        else if (avs_address == `SEEB_OFS_ADDR)
            rmux = {21'h0, addr_q};
        else if (avs_address == `SEEB_OFS_STAT)
            rmux = {30'h0, nack_q, busy_q};
        else if (avs_address == `SEEB_OFS_CTRL)
            rmux = {20'h0, n_q, 1'b0, cs_q, 2'b00, op_q};
    end

    // one wait cycle for every access
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            wait_q <= 1'b1;
            rdata_q <= 32'h0;
        end
        else if ((avs_read || avs_write) && wait_q)
        begin
            wait_q <= 1'b0;
            rdata_q <= rmux;
        end
        else
        begin
            wait_q <= 1'b1;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (we && is_data)
            wbuf_q[avs_address[5:2]] <= avs_writedata[7:0];
    end

    // ****************************************
    // bit engine
    // ****************************************
    logic [15:0] qc_q;
    logic tick;
    seeb_mst_t st_q;
    logic [1:0] q_q;
    logic [3:0] bit_q;
    logic [4:0] bi_q;
    logic ph_q;
    logic [7:0] rx_q;
    logic ackrx_q;
    logic [1:0] sda_s_q;
    logic go;
    logic rdg;
    logic [7:0] bsel;
    logic [4:0] ridx;
    logic last_rd;
    logic [7:0] ctl;
    assign tick = qc_q == 16'h0;
    assign go = we && avs_address == `SEEB_OFS_CTRL && !busy_q;
    assign ridx = bi_q - 5'h1;
    assign last_rd = ridx[3:0] == n_q;
    assign rdg = bi_q != 5'h0 && (op_q == OP_CUR_READ || (op_q == OP_RAND_READ && ph_q));
    // read control only for the current read and after a restart
    assign ctl = {1'b1, cs_q, addr_q[10:8], ph_q || op_q == OP_CUR_READ};
    assign bsel = (bi_q == 5'h0) ? ctl : (bi_q == 5'h1) ? addr_q[7:0]
                  : wbuf_q[4'(bi_q - 5'h2)];

    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            qc_q <= 16'h0;
            sda_s_q <= 2'h3;
        end
        else
        begin
            qc_q <= tick ? 16'(QTR - 1) : qc_q - 16'h1;
            sda_s_q <= {sda_s_q[0], bus.sda};
        end
    end

    always_ff @(posedge mclk)
    begin
        if (tick && st_q == MST_BIT && q_q == 2'h2 && bit_q == 4'h7 && rdg)
            rbuf_q[ridx[3:0]] <= {rx_q[6:0], sda_s_q[1]};
    end

    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            st_q <= MST_IDLE;
            q_q <= 2'h0;
            bit_q <= 4'h0;
            bi_q <= 5'h0;
            ph_q <= 1'b0;
            rx_q <= 8'h0;
            ackrx_q <= 1'b0;
            busy_q <= 1'b0;
            nack_q <= 1'b0;
            op_q <= 2'h0;
            cs_q <= 3'h0;
            n_q <= 4'h0;
            addr_q <= 11'h0;
        end
        else
        begin
            if (we && avs_address == `SEEB_OFS_ADDR)
                addr_q <= avs_writedata[10:0];
            if (go)
            begin
                op_q <= avs_writedata[`SEEB_CTRL_OP_LSB +: 2];
                cs_q <= avs_writedata[`SEEB_CTRL_CS_LSB +: 3];
                n_q <= avs_writedata[`SEEB_CTRL_CNT_LSB +: 4];
                busy_q <= 1'b1;
                nack_q <= 1'b0;
                ph_q <= 1'b0;
                bi_q <= 5'h0;
                st_q <= MST_START;
                q_q <= 2'h0;
            end
            else if (tick && st_q != MST_IDLE)
            begin
                q_q <= q_q + 2'h1;
                if (st_q == MST_BIT && q_q == 2'h2)
                begin
                    rx_q <= {rx_q[6:0], sda_s_q[1]};
                    ackrx_q <= !sda_s_q[1];
                end
                if (q_q == 2'h3)
                begin
                    bit_q <= 4'h0;
                    if (st_q == MST_STOP)
                    begin
                        st_q <= MST_IDLE;
                        busy_q <= 1'b0;
                    end
                    else if (st_q == MST_START)
                        st_q <= MST_BIT;
                    else if (bit_q != 4'h8)
                        bit_q <= bit_q + 4'h1;
                    else if (!rdg && !ackrx_q)
                    begin
                        nack_q <= 1'b1;
                        st_q <= MST_STOP;
                    end
                    else if (op_q == OP_RAND_READ && !ph_q && bi_q == 5'h1)
                    begin
                        ph_q <= 1'b1;
                        bi_q <= 5'h0;
                        st_q <= MST_START;
                    end
                    else if ((op_q == OP_POLL && bi_q == 5'h0)
                             || (op_q == OP_WRITE && bi_q == {1'b0, n_q} + 5'h2)
                             || (rdg && last_rd))
                        st_q <= MST_STOP;
                    else
                        bi_q <= bi_q + 5'h1;
                end
            end
        end
    end

    // ****************************************
    // pin drive
    // ****************************************
    logic scl_c;
    logic low_c;
    logic scl_q;
    logic oe_q;
    always_comb
    begin
        scl_c = 1'b1;
        low_c = 1'b0;
        case (st_q)
            MST_START:
            begin
                scl_c = q_q == 2'h1 || q_q == 2'h2;
                low_c = q_q[1];
            end
            MST_BIT:
            begin
                scl_c = q_q == 2'h1 || q_q == 2'h2;
                if (bit_q == 4'h8)
                    low_c = rdg && !last_rd;
                else
                    low_c = !rdg && !bsel[3'd7 - bit_q[2:0]];
            end
            MST_STOP:
            begin
                scl_c = q_q != 2'h0;
                low_c = !q_q[1];
            end
            default:
            begin
                scl_c = 1'b1;
                low_c = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            scl_q <= 1'b1;
            oe_q <= 1'b0;
        end
        else
        begin
            scl_q <= scl_c;
            oe_q <= low_c;
        end
    end
    assign bus.scl = scl_q;
    assign bus.sda_m_o = 1'b0;
    assign bus.sda_m_oe = oe_q;
    assign avs_readdata = rdata_q;
    assign avs_waitrequest = wait_q;
endmodule
`default_nettype wire

// file: tb/seeb_properties.sv
`timescale 1ns/1ps
`default_nettype none
module seeb_properties #(
    parameter int TWR_CYC = 2000
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic scl,
    input wire logic sda_m_oe,
    input wire logic sda_s_oe,
    input wire logic sda,
    input wire logic write_protect,
    input wire logic write_busy
);
    logic [31:0] busy_q;
    logic [7:0] stop_q;
    logic sda_q;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    // ****************
    // helper counters
    // ****************
    always_ff @(posedge mclk)
    begin
        sda_q <= sda;
        busy_q <= (rstn && write_busy) ? busy_q + 32'h1 : 32'h0;
        if (!rstn || (scl && sda && !sda_q))
            stop_q <= 8'h00;
        else if (stop_q != 8'hFF)
            stop_q <= stop_q + 8'h01;
    end
    // ****************
    // properties
    // ****************
    a_hold_hi_phase: assert property (($rose(scl) && sda_s_oe) |->
        (sda_s_oe throughout (##[1:64] $fell(scl)))) else $error("slave drive lost in clock high");
    a_oe_scl_low: assert property ($changed(sda_s_oe) |-> !scl && !$past(scl))
        else $error("slave drive moved near clock high");
    a_busy_no_ack: assert property (write_busy |-> !sda_s_oe)
        else $error("slave drove sda while busy");
    a_wp_no_busy: assert property ((write_protect && $past(write_protect, 3)) |->
        !$rose(write_busy)) else $error("write cycle under protect");
    a_busy_length: assert property ($fell(write_busy) |->
        (busy_q >= TWR_CYC - 4) && (busy_q <= TWR_CYC + 4)) else $error("busy length wrong");
    a_busy_after_stop: assert property ($rose(write_busy) |-> stop_q < 8'd64)
        else $error("write cycle without stop");
    a_stop_release: assert property ((scl && $rose(sda)) |-> !sda_s_oe [*8])
        else $error("slave drove after stop");
    a_scl_high_min: assert property ($rose(scl) |-> scl [*8])
        else $error("clock high too short");
    c_busy: cover property ($rose(write_busy));
    c_slave_drive: cover property ($rose(sda_s_oe));
    c_stop: cover property (scl && $rose(sda));
endmodule
`default_nettype wire

// file: tb/serial_eeprom_bus_slave_tb.sv
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_bus_slave_tb;
    import seeb_pkg::*;
    localparam int TWR = 2000;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [2:0] pins = 3'h0;
    logic [2:0] cs_ok;
    logic write_protect = 1'b0;
    logic write_busy;
    int mismatches = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [7:0] mem [0:2047];
    logic [10:0] ptr;
    logic [31:0] rd;
    seeb_if bus ();
    seeb_master #(.QTR(8), .PAGE(16)) seeb_master_inst (.mclk(mclk), .rstn(rstn),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .bus(bus.master));
    seeb_slave #(.TWR_CYC(TWR), .AW(11), .PAGE(16)) seeb_slave_inst (.mclk(mclk),
        .rstn(rstn), .bus(bus.slave), .chip_select_pin_low(pins[0]),
        .chip_select_pin_mid_inverted(pins[1]), .chip_select_pin_high(pins[2]),
        .write_protect(write_protect), .write_busy(write_busy));
    seeb_properties #(.TWR_CYC(TWR)) seeb_properties_inst (.mclk(mclk), .rstn(rstn),
        .scl(bus.scl), .sda_m_oe(bus.sda_m_oe), .sda_s_oe(bus.sda_s_oe), .sda(bus.sda),
        .write_protect(write_protect), .write_busy(write_busy));
    // middle select bit is sent inverted against its pin
    assign cs_ok = {pins[2], ~pins[1], pins[0]};
    always #2.5 mclk = ~mclk;
    // ****************
    // tasks
    // ****************
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic access(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge mclk);
        while (avs_waitrequest !== 1'b0)
            @(posedge mclk);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic run(input seeb_op_t op, input logic [2:0] cs, input int n);
        access(1'b1, 8'h00, {20'h0, 4'(n - 1), 1'b0, cs, 2'b00, op});
        rd = 32'h1;
        while (rd[0] !== 1'b0)
            access(1'b0, 8'h08, 32'h0);
    endtask
    task automatic page_write(input logic [10:0] a);
        logic [7:0] b;
        int polls;
        for (int i = 0; i < 16; i++)
        begin
            b = 8'($urandom);
            access(1'b1, 8'(8'h40 + 4 * i), {24'h0, b});
            if (!write_protect)
                mem[{a[10:4], 4'(a[3:0] + i)}] = b;
        end
        access(1'b1, 8'h04, {21'h0, a});
        run(OP_WRITE, cs_ok, 16);
        check("write nack", {31'h0, rd[1]}, 32'h0);
        polls = 0;
        do
        begin
            run(OP_POLL, cs_ok, 1);
            polls++;
        end while (rd[1] && polls < 100);
        check("poll nacked", {31'h0, polls > 1}, {31'h0, !write_protect});
    endtask
    task automatic read_back(input seeb_op_t op, input int n);
        run(op, cs_ok, n);
        check("read nack", {31'h0, rd[1]}, 32'h0);
        for (int i = 0; i < n; i++)
        begin
            access(1'b0, 8'(8'h40 + 4 * i), 32'h0);
            check("read byte", {24'h0, rd[7:0]}, {24'h0, mem[ptr]});
            ptr = ptr + 11'h1;
        end
    endtask
    // ****************
    // sequence
    // ****************
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 90000)
        begin
            mismatches++;
            test_done();
        end
    end
    initial
    begin
        void'($urandom(32'h77C5DDC6));
        repeat (20) @(posedge mclk);
        pins <= 3'($urandom);
        rstn <= 1'b1;
        repeat (4) @(posedge mclk);
        // misaligned start wraps within its page
        page_write(11'h7F0 | 11'($urandom % 16));
        page_write(11'h000);
        $display("page writes done");
        ptr = 11'h7F8;
        access(1'b1, 8'h04, {21'h0, ptr});
        read_back(OP_RAND_READ, 16);
        // current read takes block bits from control byte
        access(1'b1, 8'h04, {21'h0, ptr});
        read_back(OP_CUR_READ, 8);
        $display("reads done");
        write_protect <= 1'b1;
        page_write(11'h7F0);
        ptr = 11'h7F0;
        access(1'b1, 8'h04, {21'h0, ptr});
        read_back(OP_RAND_READ, 16);
        write_protect <= 1'b0;
        $display("protect done");
        for (int k = 0; k < 3; k++)
        begin
            run(OP_RAND_READ, cs_ok ^ 3'(1 << k), 1);
            check("select nack", {31'h0, rd[1]}, 32'h1);
        end
        $display("select done");
        test_done();
    end
endmodule
`default_nettype wire
